// ===== verilog/opc_pkg.sv
// Constants, register map and field layout of the output and PWM control bank
package opc_pkg;

  // ----------------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_HZ  = CLK_MHZ * 1000000;

  // ----------------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------------------------------------
  localparam int unsigned IDX_W      = 8;
  localparam logic [7:0]  IDX_GUARD  = 8'h20;
  localparam logic [7:0]  IDX_STATUS = 8'h21;
  localparam logic [7:0]  IDX_ROUTE  = 8'h27;
  localparam logic [7:0]  IDX_CCM    = 8'h2c;
  localparam logic [7:0]  IDX_OCR    = 8'h30;
  localparam logic [7:0]  IDX_REG2   = 8'h31;
  localparam logic [7:0]  IDX_DUTY0  = 8'h32;
  localparam logic [7:0]  IDX_DUTY4  = 8'h36;
  localparam logic [7:0]  IDX_FREQ   = 8'h37;
  localparam int unsigned REG_W      = 24;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned GUARD_PUMP_BIT = 7;
  localparam int unsigned GUARD_SUPV_BIT = 6;
  localparam int unsigned ROUTE16_LSB    = 5;
  localparam int unsigned ROUTE45_LSB    = 3;
  localparam int unsigned PUMP_BIT       = 2;
  localparam int unsigned SUPV_BIT       = 1;
  localparam int unsigned TSD_BIT        = 20;
  localparam int unsigned CCM0_BIT       = 13;
  localparam int unsigned CCM_HI_LSB     = 0;
  localparam int unsigned CCM_HI_N       = 9;
  localparam int unsigned OCR_HS7_ON_LSB = 10;
  localparam int unsigned OCR_HS_ON_LSB  = 8;
  localparam int unsigned OCR_HB_ON_LSB  = 6;
  localparam int unsigned OCR_HS7_F_LSB  = 4;
  localparam int unsigned OCR_HS_F_LSB   = 2;
  localparam int unsigned OCR_HB_F_LSB   = 0;
  localparam int unsigned OCR_W          = 12;
  localparam int unsigned REG2_BIT       = 0;
  localparam int unsigned ODD_LSB        = 12;
  localparam int unsigned EVEN_LSB       = 0;
  localparam int unsigned DUTY_W         = 10;
  localparam int unsigned NCH            = 10;
  localparam int unsigned NPAIR          = 5;

  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [1:0]        ROUTE_OFF = 2'h0;
  localparam logic [OCR_W-1:0]  OCR_RST   = 12'h540;
  localparam logic [1:0]        GUARD_RST = 2'h2;
  localparam logic [DUTY_W-1:0] DUTY_MAX  = 10'h3ff;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned ON_US   [4] = '{88, 80, 72, 64};
  localparam int unsigned RATE_HZ [4] = '{1700, 2200, 3000, 4400};
  localparam int unsigned ON_W        = 14;
  localparam int unsigned PER_W       = 17;
  localparam int unsigned PWM_FAST_HZ = 200;
  localparam int unsigned PWM_STEPS   = 1024;
  localparam int unsigned STEP_CYC    = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
  localparam int unsigned STEP_W      = 10;
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);

  // ----------------------------------------------------------------------
  // Pin synchroniser slots
  // ----------------------------------------------------------------------
  localparam int unsigned SY_PWM16 = 0;
  localparam int unsigned SY_PWM45 = 1;
  localparam int unsigned SY_FAIL  = 2;
  localparam int unsigned SY_STBY  = 3;
  localparam int unsigned SY_LOW   = 4;
  localparam int unsigned SY_N     = 5;

endpackage

// ===== verilog/opc_output_pwm_ctrl.sv
// Output routing, pump, supervision, recovery timing and PWM control bank
// ------------------------------------------------------------------------
// Behaviour
// [RULE1] Route field 16: 00 off plus direction two, 01 bridge one, 10 six, 11 both.
// [RULE2] Route field 45: 00 off, 01 bridge four, 10 bridge five, 11 both.
// [RULE3] Pump runs while shutdown bit is 0, stops while it is 1.
// [RULE4] Setting pump shutdown only takes effect while its guard is 1.
// [RULE5] Supervision bit 0: watchdog off in standby only below load threshold.
// [RULE6] Setting supervision-off only takes effect while its config guard is 1.
// [RULE7] Cluster thermal warning and shutdown active only while enable bit is 1.
// [RULE8] One constant-current enable per high-side driver, bit 13 and bits 8..0.
// [RULE9] Driver seven recovery on-time: 88, 80 default, 72, 64 us.
// [RULE10] Blanking counts inside the programmed on-time, never added after.
// [RULE11] Bits 9:8 give on-time for drivers eight to ten and electrochromic.
// [RULE12] Bits 7:6 give on-time for the six half bridges, default 01.
// [RULE13] Driver seven recovery rate: 1.7, 2.2, 3.0, 4.4 kHz, default 1.7.
// [RULE14] Bits 3:2 give rate for drivers eight to ten and electrochromic.
// [RULE15] Bits 1:0 give rate for half bridges one to six.
// [RULE16] Second regulator tracks the first while mode bit is 0, else independent.
// [RULE17] Mode bit writes are ignored during fail-safe.
// [RULE18] Software should switch the second regulator off before changing mode.
// [RULE19] Five duty registers, each odd channel at 21:12, next channel at 9:0.
// [RULE20] On-time is n/1024 of the period; code zero keeps output off.
// [RULE21] Full on needs the output ON configuration, not a duty code.
// [RULE22] One rate bit per channel: 0 gives 100 Hz, 1 gives 200 Hz.
// [RULE23] Pump guard at bit 7 blocks setting shutdown when 0; default 1.
// [RULE24] 10-bit counter wraps every 1024 steps; duty changes only at wrap.
// [RULE25] Reserved bits read zero and writes to them are dropped.
// ------------------------------------------------------------------------
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module opc_output_pwm_ctrl
  import opc_pkg::*;
#(
  parameter int unsigned ON_CYC  [4] = '{ON_US[0] * CLK_MHZ, ON_US[1] * CLK_MHZ,
                                         ON_US[2] * CLK_MHZ, ON_US[3] * CLK_MHZ},
  parameter int unsigned PER_CYC [4] = '{CLK_HZ / RATE_HZ[0], CLK_HZ / RATE_HZ[1],
                                         CLK_HZ / RATE_HZ[2], CLK_HZ / RATE_HZ[3]}
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [9:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output var  logic [31:0]       prdata_o,
  output var  logic              pready_o,
  output var  logic              pslverr_o,
  // Pins from the device core
  input  wire logic              pwm16_i,
  input  wire logic              pwm45_i,
  input  wire logic              fail_safe_i,
  input  wire logic              reg1_standby_i,
  input  wire logic              load_below_thr_i,
  // Bridge low-side gating
  output var  logic              half_bridge_one_ls_o,
  output var  logic              half_bridge_six_ls_o,
  output var  logic              half_bridge_four_ls_o,
  output var  logic              half_bridge_five_ls_o,
  output var  logic              direction_two_enable_o,
  // Supply and protection controls
  output var  logic              charge_pump_on_o,
  output var  logic              watchdog_disable_o,
  output var  logic              thermal_cluster_en_o,
  output var  logic [NCH-1:0]    const_current_en_o,
  output var  logic              reg2_independent_o,
  // Overcurrent recovery timing
  output var  logic [ON_W-1:0]   hs7_recovery_on_cyc_o,
  output var  logic [ON_W-1:0]   hs_group_recovery_on_cyc_o,
  output var  logic [ON_W-1:0]   bridge_recovery_on_cyc_o,
  output var  logic [PER_W-1:0]  hs7_recovery_per_cyc_o,
  output var  logic [PER_W-1:0]  hs_group_recovery_per_cyc_o,
  output var  logic [PER_W-1:0]  bridge_recovery_per_cyc_o,
  // PWM channels, channel one at bit 0
  output var  logic [NCH-1:0]    pwm_channel_o
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
    return a[9:2] == idx;
  endfunction

  function automatic logic [ON_W-1:0] on_cyc(input logic [1:0] code);
    return ON_W'(ON_CYC[code]);
  endfunction

  function automatic logic [PER_W-1:0] per_cyc(input logic [1:0] code);
    return PER_W'(PER_CYC[code]);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [SY_N-1:0] sync1_reg;
  logic [SY_N-1:0] sync2_reg;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {load_below_thr_i, reg1_standby_i, fail_safe_i, pwm45_i, pwm16_i};
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // APB handshake, one wait state
  // ----------------------------------------------------------------------
  logic             access;
  logic             wr_en;
  logic [7:0]       idx;
  logic [REG_W-1:0] rd_word;
  logic             rd_ok;

  assign access = psel_i && penable_i;
  assign wr_en  = access && pready_o && pwrite_i;
  assign idx    = paddr_i[9:2];

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [1:0]        guard_reg;
  logic [1:0]        route16_reg;
  logic [1:0]        route45_reg;
  logic              pump_reg;
  logic              supv_reg;
  logic              tsd_reg;
  logic [NCH-1:0]    ccm_reg;
  logic [OCR_W-1:0]  ocr_reg;
  logic              reg2_reg;
  logic [NCH-1:0]    rate_reg;
  logic [DUTY_W-1:0] duty_reg [NCH];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      guard_reg <= GUARD_RST; // [RULE23]
    end else if (wr_en && hit(paddr_i, IDX_GUARD)) begin
      guard_reg <= {pwdata_i[GUARD_PUMP_BIT], pwdata_i[GUARD_SUPV_BIT]};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      route16_reg <= ROUTE_OFF;
      route45_reg <= ROUTE_OFF;
      pump_reg    <= 1'b0;
      supv_reg    <= 1'b0;
    end else if (wr_en && hit(paddr_i, IDX_ROUTE)) begin
      route16_reg <= pwdata_i[ROUTE16_LSB +: 2];
      route45_reg <= pwdata_i[ROUTE45_LSB +: 2];
      // Clearing always allowed, setting needs the guard
      if (!pwdata_i[PUMP_BIT] || guard_reg[1]) begin
        pump_reg <= pwdata_i[PUMP_BIT]; // [RULE4] [RULE23]
      end
      if (!pwdata_i[SUPV_BIT] || guard_reg[0]) begin
        supv_reg <= pwdata_i[SUPV_BIT]; // [RULE6]
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tsd_reg <= 1'b0;
      ccm_reg <= '0;
    end else if (wr_en && hit(paddr_i, IDX_CCM)) begin
      tsd_reg <= pwdata_i[TSD_BIT];
      ccm_reg <= {pwdata_i[CCM0_BIT], pwdata_i[CCM_HI_LSB +: CCM_HI_N]}; // [RULE8]
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ocr_reg <= OCR_RST; // [RULE9] [RULE12]
    end else if (wr_en && hit(paddr_i, IDX_OCR)) begin
      ocr_reg <= pwdata_i[OCR_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg2_reg <= 1'b0;
    end else if (wr_en && hit(paddr_i, IDX_REG2) && !sync2_reg[SY_FAIL]) begin
      // No interlock against a running regulator; software must sequence it
      reg2_reg <= pwdata_i[REG2_BIT]; // [RULE17]
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rate_reg <= '0;
    end else if (wr_en && hit(paddr_i, IDX_FREQ)) begin
      rate_reg <= pwdata_i[NCH-1:0]; // [RULE22]
    end
  end

  for (genvar p = 0; p < NPAIR; p++) begin : g_duty
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        duty_reg[2*p]   <= '0;
        duty_reg[2*p+1] <= '0;
      end else if (wr_en && hit(paddr_i, IDX_W'(IDX_DUTY0 + p))) begin
        duty_reg[2*p]   <= pwdata_i[ODD_LSB +: DUTY_W];  // [RULE19]
        duty_reg[2*p+1] <= pwdata_i[EVEN_LSB +: DUTY_W]; // [RULE19]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] k;
    k       = 3'(idx - IDX_DUTY0);
    rd_word = '0; // [RULE25]
    rd_ok   = 1'b1;
    unique case (idx)
      IDX_GUARD: begin
        rd_word[GUARD_PUMP_BIT] = guard_reg[1];
        rd_word[GUARD_SUPV_BIT] = guard_reg[0];
      end
      IDX_STATUS: begin
        rd_word[3:0] = {charge_pump_on_o, watchdog_disable_o,
                        sync2_reg[SY_STBY], sync2_reg[SY_FAIL]};
      end
      IDX_ROUTE: begin
        rd_word[ROUTE16_LSB +: 2] = route16_reg;
        rd_word[ROUTE45_LSB +: 2] = route45_reg;
        rd_word[PUMP_BIT]         = pump_reg;
        rd_word[SUPV_BIT]         = supv_reg;
      end
      IDX_CCM: begin
        rd_word[TSD_BIT]                 = tsd_reg;
        rd_word[CCM0_BIT]                = ccm_reg[NCH-1];
        rd_word[CCM_HI_LSB +: CCM_HI_N]  = ccm_reg[CCM_HI_N-1:0];
      end
      IDX_OCR:  rd_word[OCR_W-1:0] = ocr_reg;
      IDX_REG2: rd_word[REG2_BIT]  = reg2_reg;
      IDX_FREQ: rd_word[NCH-1:0]   = rate_reg;
      default: begin
        if (idx >= IDX_DUTY0 && idx <= IDX_DUTY4) begin
          rd_word[ODD_LSB +: DUTY_W]  = duty_reg[{k, 1'b0}];
          rd_word[EVEN_LSB +: DUTY_W] = duty_reg[{k, 1'b1}];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= access && !pready_o;
      pslverr_o <= access && !pready_o && !rd_ok;
      prdata_o  <= (access && !pready_o && !pwrite_i) ? {8'h00, rd_word} : '0;
    end
  end

  // ----------------------------------------------------------------------
  // PWM time base
  // ----------------------------------------------------------------------
  // One prescaler serves both rates; the slow counter steps every other tick
  logic [STEP_W-1:0] step_cnt_reg;
  logic              slow_phase_reg;
  logic [DUTY_W-1:0] cnt_fast_reg;
  logic [DUTY_W-1:0] cnt_slow_reg;
  logic              fast_tick;
  logic              slow_tick;
  logic              fast_wrap;
  logic              slow_wrap;

  assign fast_tick = step_cnt_reg == STEP_LAST;
  assign slow_tick = fast_tick && slow_phase_reg;
  assign fast_wrap = fast_tick && cnt_fast_reg == DUTY_MAX; // [RULE24]
  assign slow_wrap = slow_tick && cnt_slow_reg == DUTY_MAX; // [RULE24]

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      step_cnt_reg   <= '0;
      slow_phase_reg <= 1'b0;
      cnt_fast_reg   <= '0;
      cnt_slow_reg   <= '0;
    end else begin
      step_cnt_reg <= fast_tick ? '0 : step_cnt_reg + 1'b1;
      if (fast_tick) begin
        slow_phase_reg <= !slow_phase_reg;
        cnt_fast_reg   <= cnt_fast_reg + 1'b1; // [RULE24]
      end
      if (slow_tick) begin
        cnt_slow_reg <= cnt_slow_reg + 1'b1; // [RULE24]
      end
    end
  end

  // ----------------------------------------------------------------------
  // PWM channels
  // ----------------------------------------------------------------------
  // Shadow copies stop a mid-period write from truncating a pulse
  logic [DUTY_W-1:0] duty_act_reg [NCH];
  logic [NCH-1:0]    rate_act_reg;

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic              wrap;
    logic [DUTY_W-1:0] cnt;
    assign wrap = rate_act_reg[c] ? fast_wrap : slow_wrap;
    assign cnt  = rate_act_reg[c] ? cnt_fast_reg : cnt_slow_reg;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        duty_act_reg[c]  <= '0;
        rate_act_reg[c]  <= 1'b0;
        pwm_channel_o[c] <= 1'b0;
      end else begin
        if (wrap) begin
          duty_act_reg[c] <= duty_reg[c]; // [RULE24]
          rate_act_reg[c] <= rate_reg[c]; // [RULE22]
        end
        // Code n is high for n of 1024 steps, so never fully on
        pwm_channel_o[c] <= cnt < duty_act_reg[c]; // [RULE20]
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_bridge_one_ls_o   <= 1'b0;
      half_bridge_six_ls_o   <= 1'b0;
      half_bridge_four_ls_o  <= 1'b0;
      half_bridge_five_ls_o  <= 1'b0;
      direction_two_enable_o <= 1'b1;
      charge_pump_on_o       <= 1'b1;
      watchdog_disable_o     <= 1'b0;
      thermal_cluster_en_o   <= 1'b0;
      const_current_en_o     <= '0;
      reg2_independent_o     <= 1'b0;
    end else begin
      half_bridge_one_ls_o   <= route16_reg[0] && sync2_reg[SY_PWM16]; // [RULE1]
      half_bridge_six_ls_o   <= route16_reg[1] && sync2_reg[SY_PWM16]; // [RULE1]
      direction_two_enable_o <= route16_reg == ROUTE_OFF;              // [RULE1]
      half_bridge_four_ls_o  <= route45_reg[0] && sync2_reg[SY_PWM45]; // [RULE2]
      half_bridge_five_ls_o  <= route45_reg[1] && sync2_reg[SY_PWM45]; // [RULE2]
      charge_pump_on_o       <= !pump_reg;                             // [RULE3]
      watchdog_disable_o     <= sync2_reg[SY_STBY]
                                && (supv_reg || sync2_reg[SY_LOW]);    // [RULE5]
      thermal_cluster_en_o   <= tsd_reg;                               // [RULE7]
      const_current_en_o     <= ccm_reg;                               // [RULE8]
      reg2_independent_o     <= reg2_reg;                              // [RULE16]
    end
  end

  // Figures already include blanking; the driver starts counting at turn-on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hs7_recovery_on_cyc_o       <= '0;
      hs_group_recovery_on_cyc_o  <= '0;
      bridge_recovery_on_cyc_o    <= '0;
      hs7_recovery_per_cyc_o      <= '0;
      hs_group_recovery_per_cyc_o <= '0;
      bridge_recovery_per_cyc_o   <= '0;
    end else begin
      hs7_recovery_on_cyc_o       <= on_cyc(ocr_reg[OCR_HS7_ON_LSB +: 2]); // [RULE9] [RULE10]
      hs_group_recovery_on_cyc_o  <= on_cyc(ocr_reg[OCR_HS_ON_LSB +: 2]);  // [RULE11]
      bridge_recovery_on_cyc_o    <= on_cyc(ocr_reg[OCR_HB_ON_LSB +: 2]);  // [RULE12]
      hs7_recovery_per_cyc_o      <= per_cyc(ocr_reg[OCR_HS7_F_LSB +: 2]); // [RULE13]
      hs_group_recovery_per_cyc_o <= per_cyc(ocr_reg[OCR_HS_F_LSB +: 2]);  // [RULE14]
      bridge_recovery_per_cyc_o   <= per_cyc(ocr_reg[OCR_HB_F_LSB +: 2]);  // [RULE15]
    end
  end

endmodule // opc_output_pwm_ctrl

`default_nettype wire

// ===== tb/opc_output_pwm_ctrl_sva.sv
// Port checker for the output and PWM control bank
`timescale 1ns/1ps
`default_nettype none
module opc_ctrl_sva (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Pins and outputs
  input wire logic        pwm16_i,
  input wire logic        pwm45_i,
  input wire logic        fail_safe_i,
  input wire logic        reg1_standby_i,
  input wire logic        load_below_thr_i,
  input wire logic        half_bridge_one_ls_o,
  input wire logic        half_bridge_six_ls_o,
  input wire logic        half_bridge_four_ls_o,
  input wire logic        half_bridge_five_ls_o,
  input wire logic        direction_two_enable_o,
  input wire logic        watchdog_disable_o,
  input wire logic        reg2_independent_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  ready_wait_a: assert property ($rose(penable_i) && psel_i |=> pready_o)
    else $error("ready late");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
  ready_owner_a: assert property (pready_o |-> psel_i && penable_i) else $error("stray ready");
  error_data_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response with data");
  idle_data_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("data off cycle");
  route_dir_a: assert property (direction_two_enable_o |->
    !(half_bridge_one_ls_o || half_bridge_six_ls_o)) else $error("routed with direction two");
  pin_one_six_a: assert property (half_bridge_one_ls_o || half_bridge_six_ls_o |->
    $past(pwm16_i, 3)) else $error("bridge one or six without pin");
  pin_four_five_a: assert property (half_bridge_four_ls_o || half_bridge_five_ls_o |->
    $past(pwm45_i, 3)) else $error("bridge four or five without pin");
  wd_cause_a: assert property (watchdog_disable_o |-> $past(reg1_standby_i, 3))
    else $error("watchdog off outside standby");
  wd_load_a: assert property ($past(reg1_standby_i, 3) && $past(load_below_thr_i, 3)
    |-> watchdog_disable_o) else $error("watchdog kept under low load");
  failsafe_hold_a: assert property (fail_safe_i [*6] |=> $stable(reg2_independent_o))
    else $error("mode changed in fail-safe");
  cover property (pslverr_o);
  cover property ($rose(watchdog_disable_o));
  cover property (half_bridge_four_ls_o && half_bridge_five_ls_o);
endmodule // opc_ctrl_sva
`default_nettype wire

// ===== tb/opc_output_pwm_ctrl_bench.sv
// Self-checking bench for the output and PWM control bank
`timescale 1ns/1ps
`default_nettype none
module opc_output_pwm_ctrl_bench;
  import opc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic pwm16_i = 0, pwm45_i = 0, fail_safe_i = 0, reg1_standby_i = 0, load_below_thr_i = 0;
  logic [9:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, half_bridge_one_ls_o, half_bridge_six_ls_o, er;
  logic half_bridge_four_ls_o, half_bridge_five_ls_o, direction_two_enable_o;
  logic charge_pump_on_o, watchdog_disable_o, thermal_cluster_en_o, reg2_independent_o;
  logic [NCH-1:0] const_current_en_o, pwm_channel_o;
  logic [ON_W-1:0] hs7_recovery_on_cyc_o, hs_group_recovery_on_cyc_o, bridge_recovery_on_cyc_o;
  logic [PER_W-1:0] hs7_recovery_per_cyc_o, hs_group_recovery_per_cyc_o;
  logic [PER_W-1:0] bridge_recovery_per_cyc_o;
  int bad_count = 0, total_checks = 0, cyc = 0;
  // Shortened recovery counts keep the table checks quick
  localparam int unsigned TON [4] = '{8, 7, 6, 5};
  localparam int unsigned TPER [4] = '{40, 30, 20, 10};

  opc_output_pwm_ctrl #(.ON_CYC(TON), .PER_CYC(TPER)) u_dut (.clk_i, .arst_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pwm16_i,
    .pwm45_i, .fail_safe_i, .reg1_standby_i, .load_below_thr_i, .half_bridge_one_ls_o,
    .half_bridge_six_ls_o, .half_bridge_four_ls_o, .half_bridge_five_ls_o,
    .direction_two_enable_o, .charge_pump_on_o, .watchdog_disable_o, .thermal_cluster_en_o,
    .const_current_en_o, .reg2_independent_o, .hs7_recovery_on_cyc_o,
    .hs_group_recovery_on_cyc_o, .bridge_recovery_on_cyc_o, .hs7_recovery_per_cyc_o,
    .hs_group_recovery_per_cyc_o, .bridge_recovery_per_cyc_o, .pwm_channel_o);

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Idle edge first, so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= {i, 2'b00};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(rd, e);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] k;
    logic [3:0] q;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    wt(2);
    chk(hs7_recovery_on_cyc_o, TON[1]);
    chk(bridge_recovery_per_cyc_o, TPER[0]);
    chk({charge_pump_on_o, direction_two_enable_o}, 32'h3);
    rdc(IDX_GUARD, 32'h80);
    rdc(IDX_OCR, 32'h540);
    rdc(IDX_FREQ, 32'h0);
    for (int c = 0; c < 4; c++) begin
      k = 2'(c);
      apb(1'b1, IDX_OCR, {20'h0, {6{k}}});
      wt(3);
      chk(hs7_recovery_on_cyc_o, TON[k]);
      chk(hs_group_recovery_on_cyc_o, TON[k]);
      chk(bridge_recovery_on_cyc_o, TON[k]);
      chk(hs7_recovery_per_cyc_o, TPER[k]);
      chk(hs_group_recovery_per_cyc_o, TPER[k]);
      chk(bridge_recovery_per_cyc_o, TPER[k]);
      rdc(IDX_OCR, {20'h0, {6{k}}});
    end
    apb(1'b1, IDX_ROUTE, 32'h6);
    rdc(IDX_ROUTE, 32'h4);
    chk(charge_pump_on_o, 32'h0);
    apb(1'b1, IDX_ROUTE, 32'h0);
    apb(1'b1, IDX_GUARD, 32'h40);
    apb(1'b1, IDX_ROUTE, 32'h6);
    rdc(IDX_ROUTE, 32'h2);
    reg1_standby_i <= 1'b1;
    wt(4);
    chk(watchdog_disable_o, 32'h1);
    apb(1'b1, IDX_ROUTE, 32'h0);
    wt(3);
    chk(watchdog_disable_o, 32'h0);
    load_below_thr_i <= 1'b1;
    wt(4);
    chk(watchdog_disable_o, 32'h1);
    reg1_standby_i <= 1'b0;
    pwm16_i <= 1'b1;
    pwm45_i <= 1'b1;
    apb(1'b1, IDX_GUARD, 32'h80);
    // Reserved ones written alongside every route pair
    for (int r = 0; r < 16; r++) begin
      q = 4'(r);
      apb(1'b1, IDX_ROUTE, 32'hffffff81 | {q, 3'b000});
      wt(4);
      chk({half_bridge_one_ls_o, half_bridge_six_ls_o, half_bridge_four_ls_o,
        half_bridge_five_ls_o, direction_two_enable_o}, {q[2], q[3], q[0], q[1], q[3:2] == 2'b00});
      rdc(IDX_ROUTE, {q, 3'b000});
    end
    apb(1'b1, IDX_CCM, 32'hffffffff);
    rdc(IDX_CCM, 32'h1021ff);
    chk({thermal_cluster_en_o, const_current_en_o}, 32'h7ff);
    fail_safe_i <= 1'b1;
    wt(4);
    apb(1'b1, IDX_REG2, 32'h1);
    rdc(IDX_REG2, 32'h0);
    fail_safe_i <= 1'b0;
    wt(4);
    apb(1'b1, IDX_REG2, 32'hffffffff);
    rdc(IDX_REG2, 32'h1);
    chk(reg2_independent_o, 32'h1);
    for (int p = 0; p < 5; p++) begin
      apb(1'b1, IDX_DUTY0 + 8'(p), 32'hffffffff);
      rdc(IDX_DUTY0 + 8'(p), 32'h3ff3ff);
    end
    apb(1'b1, IDX_FREQ, 32'hffffffff);
    rdc(IDX_FREQ, 32'h3ff);
    // New duty waits for the period wrap, far beyond this run
    wt(1000);
    chk(pwm_channel_o, 32'h0);
    apb(1'b0, 8'h22, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    test_done();
  end
endmodule // opc_output_pwm_ctrl_bench

bind opc_output_pwm_ctrl opc_ctrl_sva u_sva (.clk_i, .arst_n_i, .psel_i, .penable_i,
  .prdata_o, .pready_o, .pslverr_o, .pwm16_i, .pwm45_i, .fail_safe_i, .reg1_standby_i,
  .load_below_thr_i, .half_bridge_one_ls_o, .half_bridge_six_ls_o, .half_bridge_four_ls_o,
  .half_bridge_five_ls_o, .direction_two_enable_o, .watchdog_disable_o, .reg2_independent_o);
`default_nettype wire
